// ---- peak_seq_pkg.sv ----
// Shared constants and types of the peak converter sequencer
`default_nettype none
package peak_seq_pkg;
	// =============================================================
	// Clock and phase timing
	localparam int CLK_PERIOD_PS   = 5000;
	localparam int SETTLE_TIME_NS  = 600;
	localparam int DIGITISE_TIME_US = 6;
	localparam int CLEAR_TIME_NS   = 600;
	localparam int SETTLE_CYC   = (SETTLE_TIME_NS * 1000) / CLK_PERIOD_PS;
	localparam int CLEAR_CYC    = (CLEAR_TIME_NS * 1000) / CLK_PERIOD_PS;
	localparam int DIGITISE_CYC =
		(DIGITISE_TIME_US * 1000000) / CLK_PERIOD_PS;
	localparam int CNT_W = 13;

	// =============================================================
	// Structure of the converter array
	localparam int NUM_CH        = 8;
	localparam int NUM_SECTIONS  = 16;
	localparam int MUX_GROUP     = 4;
	localparam int SECT_PER_ADC  = 8;
	localparam int SLOTS         = NUM_SECTIONS / 2;
	localparam int SLOT_W        = 3;
	localparam int SLOT_CYC      = DIGITISE_CYC / SLOTS;
	localparam int ADC_W         = 12;
	localparam logic [11:0] SLIDE_MAX = 12'h0_F00;
	localparam logic [11:0] ADC_FULL  = 12'h0_FFF;

	// =============================================================
	// Types
	typedef enum logic [2:0] {
		ST_IDLE, ST_ACQUIRE, ST_SETTLE, ST_DIGITISE, ST_CLEAR
	} seq_state_e;

	typedef struct packed {
		logic [2:0]  channel;
		logic        range_low;
		logic        below_limit_flag;
		logic        overflow;
		logic [11:0] value;
	} result_s;

	typedef struct packed {
		logic [11:0] offset;
		logic        slide_enable;
		logic        keep_low_values_setting;
	} conv_cfg_s;

	typedef struct packed {
		logic [7:0]  threshold;
		logic        kill;
	} ch_limit_s;
endpackage : peak_seq_pkg
`default_nettype wire

// ---- result_filter.sv ----
// Offset removal and threshold filter for one converter block
`default_nettype none
module result_filter (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst_b,
	input  wire logic                   clk_en,
	// Sample in
	input  wire logic                   sample_valid,
	input  wire logic [11:0]            sample_raw,
	input  wire logic [2:0]             sample_channel,
	input  wire logic                   sample_range_low,
	input  wire peak_seq_pkg::ch_limit_s limit,
	input  wire peak_seq_pkg::conv_cfg_s cfg,
	// Result out
	output logic                        result_valid,
	output peak_seq_pkg::result_s       result
);
	logic [12:0] diff;
	logic [11:0] corr;
	logic        ovf;
	logic        below;
	logic        keep;

	// =============================================================
	// Offset removal and acceptance
	always_comb begin
		diff = {1'b0, sample_raw} - {1'b0, cfg.offset};
		if (cfg.slide_enable) begin
			corr = diff[12] ? 12'h0_000 : diff[11:0];
			ovf  = diff[12] || (diff[11:0] > peak_seq_pkg::SLIDE_MAX);
		end else begin
			corr = sample_raw;
			ovf  = (sample_raw == peak_seq_pkg::ADC_FULL);
		end
		below = (corr[11:4] < limit.threshold);
		keep  = !ovf && !limit.kill &&
			(!below || cfg.keep_low_values_setting);
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			result_valid <= 1'b0;
			result       <= '0;
		end else if (clk_en) begin
			result_valid <= sample_valid && keep;
			if (sample_valid) begin
				result.channel          <= sample_channel;
				result.range_low        <= sample_range_low;
				result.below_limit_flag <= below;
				result.overflow         <= ovf;
				result.value            <= corr;
			end
		end
	end

	a_drop_overflow: assert property (@(posedge core_clk) disable iff (!rst_b)
		clk_en && sample_valid && ovf |=> !result_valid)
		else $error("Overflowed sample forwarded");
endmodule : result_filter
`default_nettype wire

// ---- peak_seq.sv ----
// Conversion sequencer of the eight channel dual range peak converter
`default_nettype none
module peak_seq (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst_b,
	input  wire logic                   clk_en,
	// Front end
	input  wire logic                   gate_pin,
	input  wire logic                   analog_reset,
	output logic                        charge_switch,
	output logic                        discharge_switch,
	output logic [1:0]                  mux_sel,
	output logic                        mux_range_low,
	// Converters A and B
	output logic                        adc_start,
	input  wire logic                   adc_done,
	input  wire logic [11:0]            adc_a_data,
	input  wire logic [11:0]            adc_b_data,
	// Configuration
	input  wire peak_seq_pkg::conv_cfg_s cfg,
	input  wire peak_seq_pkg::ch_limit_s [7:0] limits,
	// Results and status
	output logic                        a_valid,
	output peak_seq_pkg::result_s       a_result,
	output logic                        b_valid,
	output peak_seq_pkg::result_s       b_result,
	output logic                        busy
);
	peak_seq_pkg::seq_state_e state_r;
	logic [2:0]  gate_sync_r;
	logic        gate_lvl_r;
	logic [12:0] cnt_r;
	logic [2:0]  slot_r;
	logic        sampled_r;
	logic        gate_rise;
	logic        gate_fall;
	logic [2:0]  ch_a;
	logic [2:0]  ch_b;

	// =============================================================
	// Gate synchroniser, common to all channels
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			gate_sync_r <= 3'h0;
			gate_lvl_r  <= 1'b0;
		end else if (clk_en) begin
			gate_sync_r <= {gate_sync_r[1:0], gate_pin};
			if (gate_sync_r[1] == gate_sync_r[2])
				gate_lvl_r <= gate_sync_r[2];
		end
	end
	assign gate_rise = (gate_sync_r[1] == gate_sync_r[2]) &&
		gate_sync_r[2] && !gate_lvl_r;
	assign gate_fall = (gate_sync_r[1] == gate_sync_r[2]) &&
		!gate_sync_r[2] && gate_lvl_r;

	// =============================================================
	// Phase sequencer
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= peak_seq_pkg::ST_IDLE;
			cnt_r   <= 13'h0_000;
		end else if (clk_en) begin
			unique case (state_r)
				peak_seq_pkg::ST_IDLE: begin
					cnt_r <= 13'h0_000;
					if (gate_rise && !analog_reset)
						state_r <= peak_seq_pkg::ST_ACQUIRE;
				end
				peak_seq_pkg::ST_ACQUIRE: begin
					if (gate_fall)
						state_r <= peak_seq_pkg::ST_SETTLE;
				end
				peak_seq_pkg::ST_SETTLE: begin
					if (cnt_r == 13'(peak_seq_pkg::SETTLE_CYC - 1)) begin
						cnt_r   <= 13'h0_000;
						state_r <= peak_seq_pkg::ST_DIGITISE;
					end else
						cnt_r <= cnt_r + 13'h0_001;
				end
				peak_seq_pkg::ST_DIGITISE: begin
					if (cnt_r == 13'(peak_seq_pkg::DIGITISE_CYC - 1)) begin
						cnt_r   <= 13'h0_000;
						state_r <= peak_seq_pkg::ST_CLEAR;
					end else
						cnt_r <= cnt_r + 13'h0_001;
				end
				peak_seq_pkg::ST_CLEAR: begin
					if (cnt_r == 13'(peak_seq_pkg::CLEAR_CYC - 1)) begin
						cnt_r   <= 13'h0_000;
						state_r <= peak_seq_pkg::ST_IDLE;
					end else
						cnt_r <= cnt_r + 13'h0_001;
				end
				default: begin
					state_r <= peak_seq_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// =============================================================
	// Slot walk: eight slots, each one section per converter
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			slot_r    <= 3'h0;
			sampled_r <= 1'b0;
			adc_start <= 1'b0;
		end else if (clk_en) begin
			adc_start <= 1'b0;
			if (state_r != peak_seq_pkg::ST_DIGITISE) begin
				slot_r    <= 3'h0;
				sampled_r <= 1'b0;
			end else if (cnt_r == 13'(32'(slot_r) *
					peak_seq_pkg::SLOT_CYC)) begin
				adc_start <= 1'b1;
				sampled_r <= 1'b0;
			end else if (adc_done && !sampled_r) begin
				sampled_r <= 1'b1;
				slot_r    <= slot_r + 3'h1;
			end
		end
	end

	// Slots 0..3 low range, 4..7 full range; A = ch 0..3, B = ch 4..7
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mux_sel       <= 2'h0;
			mux_range_low <= 1'b1;
		end else if (clk_en) begin
			mux_sel       <= slot_r[1:0];
			mux_range_low <= !slot_r[2];
		end
	end
	assign ch_a = {1'b0, slot_r[1:0]};
	assign ch_b = {1'b1, slot_r[1:0]};

	// =============================================================
	// Analog switches and busy
	assign charge_switch    = (state_r == peak_seq_pkg::ST_ACQUIRE);
	assign discharge_switch = (state_r == peak_seq_pkg::ST_CLEAR) ||
		analog_reset;
	assign busy = (state_r != peak_seq_pkg::ST_IDLE) || analog_reset;

	// =============================================================
	// Result paths for both converters
	result_filter u_filt_a (
		.core_clk        (core_clk),
		.rst_b           (rst_b),
		.clk_en          (clk_en),
		.sample_valid    (adc_done && !sampled_r &&
			state_r == peak_seq_pkg::ST_DIGITISE),
		.sample_raw      (adc_a_data),
		.sample_channel  (ch_a),
		.sample_range_low(!slot_r[2]),
		.limit           (limits[ch_a]),
		.cfg             (cfg),
		.result_valid    (a_valid),
		.result          (a_result)
	);
	result_filter u_filt_b (
		.core_clk        (core_clk),
		.rst_b           (rst_b),
		.clk_en          (clk_en),
		.sample_valid    (adc_done && !sampled_r &&
			state_r == peak_seq_pkg::ST_DIGITISE),
		.sample_raw      (adc_b_data),
		.sample_channel  (ch_b),
		.sample_range_low(!slot_r[2]),
		.limit           (limits[ch_b]),
		.cfg             (cfg),
		.result_valid    (b_valid),
		.result          (b_result)
	);

	// =============================================================
	// Checks
	// Acquire itself is left out: a quick re-gate there is legal
	a_gate_ignored: assert property (@(posedge core_clk) disable iff (!rst_b)
		clk_en && gate_rise && state_r inside {peak_seq_pkg::ST_SETTLE,
		peak_seq_pkg::ST_DIGITISE, peak_seq_pkg::ST_CLEAR}
		|=> state_r != peak_seq_pkg::ST_ACQUIRE)
		else $error("Gate accepted outside idle");
	a_clear_after_dig: assert property (@(posedge core_clk) disable iff (!rst_b)
		$fell(state_r == peak_seq_pkg::ST_DIGITISE) |-> discharge_switch)
		else $error("Clear did not follow digitising");
	a_busy_tracks: assert property (@(posedge core_clk) disable iff (!rst_b)
		charge_switch || discharge_switch |-> busy)
		else $error("Busy low during sequence");
	a_idle_after_clr: assert property (@(posedge core_clk) disable iff (!rst_b)
		$fell(state_r == peak_seq_pkg::ST_CLEAR) |-> state_r ==
		peak_seq_pkg::ST_IDLE)
		else $error("Clear not followed by idle");
	a_settle_start: assert property (@(posedge core_clk) disable iff (!rst_b)
		$rose(state_r == peak_seq_pkg::ST_SETTLE) && clk_en
		|-> ##119 state_r == peak_seq_pkg::ST_SETTLE
		##1 state_r == peak_seq_pkg::ST_DIGITISE)
		else $error("Settling phase length wrong");
	a_start_single: assert property (@(posedge core_clk) disable iff (!rst_b)
		clk_en && adc_start |=> !adc_start)
		else $error("Converter start pulse too long");
	a_acq_on_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
		clk_en && state_r == peak_seq_pkg::ST_IDLE && gate_rise &&
		!analog_reset |=> charge_switch)
		else $error("Gate did not start acquisition");
	a_kill_drops: assert property (@(posedge core_clk) disable iff (!rst_b)
		clk_en && a_valid |-> !limits[a_result.channel].kill)
		else $error("Killed channel forwarded");
	a_one_sample: assert property (@(posedge core_clk) disable iff (!rst_b)
		a_valid |=> !a_valid)
		else $error("Converter A sample doubled");
endmodule : peak_seq
`default_nettype wire

// ---- adc_model.sv ----
// Converter pair model that answers each start pulse after a set delay
`default_nettype none
module adc_model (
	// Clock
	input  wire logic        core_clk,
	// Requests from the sequencer and values to convert
	input  wire logic        adc_start,
	input  wire logic [3:0]  delay,
	input  wire logic [11:0] next_a,
	input  wire logic [11:0] next_b,
	// Converter outputs
	output logic             adc_done,
	output logic [11:0]      adc_a_data,
	output logic [11:0]      adc_b_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [4:0]  cnt_r;
	logic [11:0] a_r;
	logic [11:0] b_r;
	initial begin
		cnt_r = 5'h00;
		adc_done = 1'b0;
		adc_a_data = 12'h0_5A5;
		adc_b_data = 12'h0_A5A;
	end
	// =============================================================
	// Answer
	// Words toggle outside the done cycle, so a late sample shows junk
	always @(posedge core_clk) begin
		adc_done <= 1'b0;
		adc_a_data <= ~adc_a_data;
		adc_b_data <= ~adc_b_data;
		if (adc_start) begin
			a_r <= next_a;
			b_r <= next_b;
			cnt_r <= {1'b0, delay} + 5'h01;
		end else if (cnt_r != 5'h00) begin
			cnt_r <= cnt_r - 5'h01;
			if (cnt_r == 5'h01) begin
				adc_done <= 1'b1;
				adc_a_data <= a_r;
				adc_b_data <= b_r;
			end
		end
	end
endmodule : adc_model
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench of the conversion sequencer
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk, rst_b, clk_en, gate_pin, analog_reset;
	logic charge_switch, discharge_switch, mux_range_low, adc_start;
	logic adc_done, a_valid, b_valid, busy;
	logic [1:0]  mux_sel;
	logic [3:0]  delay, slot, k;
	logic [11:0] adc_a_data, adc_b_data, next_a, next_b;
	logic [31:0] seed;
	peak_seq_pkg::conv_cfg_s       cfg;
	peak_seq_pkg::ch_limit_s [7:0] limits;
	peak_seq_pkg::result_s         a_result, b_result, ra, rb;
	peak_seq_pkg::result_s         qa[$], qb[$];
	int fail_count, comparisons;
	peak_seq u_peak_seq (.core_clk(core_clk), .rst_b(rst_b),
		.clk_en(clk_en), .gate_pin(gate_pin), .analog_reset(analog_reset),
		.charge_switch(charge_switch), .discharge_switch(discharge_switch),
		.mux_sel(mux_sel), .mux_range_low(mux_range_low),
		.adc_start(adc_start), .adc_done(adc_done), .adc_a_data(adc_a_data),
		.adc_b_data(adc_b_data), .cfg(cfg), .limits(limits),
		.a_valid(a_valid), .a_result(a_result), .b_valid(b_valid),
		.b_result(b_result), .busy(busy));
	adc_model u_adc_model (.core_clk(core_clk), .adc_start(adc_start),
		.delay(delay), .next_a(next_a), .next_b(next_b),
		.adc_done(adc_done), .adc_a_data(adc_a_data),
		.adc_b_data(adc_b_data));
	always #2.5 core_clk = ~core_clk;
	// =============================================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// Half the words sit on the overflow and sliding limits
	function automatic logic [11:0] pick(input logic [15:0] r);
		case (r[1:0])
			2'h0: return peak_seq_pkg::ADC_FULL;
			2'h1: return cfg.offset + peak_seq_pkg::SLIDE_MAX + {11'h000, r[2]};
			default: return r[15:4];
		endcase
	endfunction : pick
	function automatic logic keep(input logic [11:0] raw, input logic [2:0] ch,
		input logic low, output peak_seq_pkg::result_s r);
		logic [12:0] d;
		d = {1'b0, raw} - (cfg.slide_enable ? {1'b0, cfg.offset} : 13'h0000);
		r.channel = ch;
		r.range_low = low;
		r.overflow = cfg.slide_enable ? (d[12] || d[11:0] > 12'h0_F00)
			: raw == 12'h0_FFF;
		r.value = d[12] ? 12'h0_000 : d[11:0];
		r.below_limit_flag = r.value[11:4] < limits[ch].threshold;
		return !r.overflow && !limits[ch].kill
			&& (!r.below_limit_flag || cfg.keep_low_values_setting);
	endfunction : keep
	task automatic chk(input string name, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (e !== g) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, e, g);
		end
	endtask : chk
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report
	// =============================================================
	// Reference model at every result
	always @(posedge core_clk) begin
		seed = lfsr(seed);
		next_a <= pick(seed[15:0]);
		next_b <= pick(seed[31:16]);
		if (adc_start)
			slot = slot + 4'h1;
		if (adc_done) begin
			k = slot - 4'h1;
			chk("mux_sel", k[1:0], mux_sel);
			chk("mux_range_low", k < 4'h4, mux_range_low);
			if (keep(adc_a_data, {1'b0, k[1:0]}, k < 4'h4, ra))
				qa.push_back(ra);
			if (keep(adc_b_data, {1'b1, k[1:0]}, k < 4'h4, rb))
				qb.push_back(rb);
		end
		if (a_valid)
			chk("a_result", qa.size() ? qa.pop_front() : 18'h0_0000, a_result);
		if (b_valid)
			chk("b_result", qb.size() ? qb.pop_front() : 18'h0_0000, b_result);
	end
	// =============================================================
	// One full gate sequence, optionally with a stray gate inside
	task automatic run_seq(input logic [3:0] dly, input logic extra);
		int n;
		int starts;
		delay <= dly;
		slot = 4'h0;
		cfg <= {4'h0, seed[7:0], seed[8], seed[9]};
		for (int c = 0; c < 8; c++)
			limits[c] <= {seed[c+:8], seed[c+9+:2] == 2'h0};
		@(posedge core_clk);
		gate_pin <= 1'b1;
		n = 0;
		while (charge_switch !== 1'b1 && n < 10) begin
			@(posedge core_clk);
			n++;
		end
		chk("charge_rise", 5, n);
		chk("busy_acquire", 1, busy);
		repeat (5) @(posedge core_clk);
		gate_pin <= 1'b0;
		n = 0;
		while (adc_start !== 1'b1 && n < 200) begin
			@(posedge core_clk);
			n++;
		end
		chk("settle_ok", 1, n >= 120 && n <= 128);
		chk("charge_open", 0, charge_switch);
		n = 0;
		starts = 1;
		while (discharge_switch !== 1'b1 && n < 1300) begin
			@(posedge core_clk);
			n++;
			starts += adc_start === 1'b1;
			gate_pin <= extra && n >= 300 && n < 310;
		end
		chk("digitise_ok", 1, n >= 1195 && n <= 1205);
		chk("start_count", 8, starts);
		n = 0;
		while (discharge_switch === 1'b1 && n < 200) begin
			@(posedge core_clk);
			n++;
		end
		chk("clear_len", 120, n);
		repeat (20) @(posedge core_clk);
		chk("idle_again", 0, {busy, charge_switch});
		chk("queues_empty", 0, qa.size() + qb.size());
	endtask : run_seq
	initial begin
		core_clk = 1'b0;
		rst_b = 1'b0;
		clk_en = 1'b1;
		gate_pin = 1'b0;
		analog_reset = 1'b0;
		delay = 4'h0;
		slot = 4'h0;
		seed = 32'h0000_7898;
		cfg = '0;
		limits = '0;
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		chk("reset_out", 6'h02, {charge_switch, discharge_switch,
			adc_start, a_valid, mux_range_low, busy});
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			run_seq(4'(i * 3), i[0]);
			$display("test sequence %0d done", i);
		end
		analog_reset <= 1'b1;
		gate_pin <= 1'b1;
		repeat (20) @(posedge core_clk);
		chk("analog_hold", 3'h6, {busy, discharge_switch, charge_switch});
		analog_reset <= 1'b0;
		gate_pin <= 1'b0;
		repeat (20) @(posedge core_clk);
		chk("analog_free", 0, {busy, discharge_switch, charge_switch});
		$display("test analog reset done");
		// Frozen clock enable must keep a held gate from starting
		clk_en <= 1'b0;
		gate_pin <= 1'b1;
		repeat (20) @(posedge core_clk);
		chk("freeze_hold", 0, {busy, charge_switch});
		gate_pin <= 1'b0;
		@(posedge core_clk);
		clk_en <= 1'b1;
		repeat (10) @(posedge core_clk);
		chk("freeze_free", 0, {busy, charge_switch});
		$display("test clock enable done");
		final_report();
	end
	// Six sequences take about 9000 cycles; twice that means a hang
	initial begin
		#100000;
		fail_count++;
		final_report();
	end
endmodule : tb
`default_nettype wire
